// >>> disp_host_pkg.sv
package disp_host_pkg;
  // Bus and word widths
  localparam int BUS_W = 18;
  localparam int SER_BITS = 8;
  localparam logic [3:0] SER_LAST = 4'h7;
  localparam logic [3:0] SER_CNT_RST = 4'h0;
  // Pin input synchroniser width: cs, mode, dc/sclk, wr/dc, rd, sda, bus
  localparam int PIN_W = 6 + BUS_W;
  localparam int PIN_CS = 0;
  localparam int PIN_MODE = 1;
  localparam int PIN_DCSCK = 2;
  localparam int PIN_WRDC = 3;
  localparam int PIN_RD = 4;
  localparam int PIN_SDA = 5;
  localparam int PIN_BUS = 6;
  // Pixel buffer: two entries, one address bit plus a wrap bit
  localparam int PIX_DEPTH = 2;
  localparam logic [1:0] PTR_RST = 2'h0;
  localparam logic [1:0] PTR_ONE = 2'h1;

  // Host interface selection, strapped by the host
  typedef enum logic [1:0] {
    MODE_PARALLEL,
    MODE_SERIAL3,
    MODE_SERIAL4,
    MODE_SERIAL2LANE
  } host_mode_t;

  // Word handed to the controller core
  typedef struct packed {
    logic is_data;
    logic [BUS_W-1:0] value;
  } host_word_t;

  // Pixel captured from the RGB path
  typedef struct packed {
    logic hsync;
    logic vsync;
    logic [BUS_W-1:0] px;
  } pixel_t;

  localparam host_word_t WORD_RST = '{is_data: 1'b0, value: 18'h00000};
endpackage : disp_host_pkg

// >>> disp_host_port.sv
`timescale 1ns/1ps
// Behaviour
// - Serial data input is sampled on each rising serial clock edge.
// - With interface mode select high, serial data pin is input only.
// - Parallel read completes at the read strobe's rising edge.
// - Data/command select high marks display data, low marks a command.
// - In four-wire serial, the write strobe pin carries data/command select.
// - In two-lane serial, the write strobe pin carries the second data lane.
// - Register select pin is data/command select parallel, serial clock serially.
// - The 18-bit parallel bus is two-way, shared by MCU and RGB paths.
// - With interface mode select low, device may drive serial read data.
// - Chip select is active low; transfers count only while it is low; the RGB pixel path here ignores chip select.
module disp_host_port (
  // Core clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Host selection and control pins
  input wire disp_host_pkg::host_mode_t i_host_mode,
  input wire logic i_interface_mode_select_bit,
  input wire logic i_chip_select_n,
  input wire logic i_dc_select_or_serial_clock,
  input wire logic i_write_strobe_or_dc_select,
  input wire logic i_read_strobe_n,
  // Serial data pin
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // Parallel pixel bus
  input wire logic [disp_host_pkg::BUS_W-1:0] i_parallel_pixel_bus,
  output logic [disp_host_pkg::BUS_W-1:0] o_parallel_pixel_bus,
  output logic o_parallel_pixel_bus_oe,
  // RGB path, dot clock domain
  input wire logic i_dot_clk,
  input wire logic i_pixel_data_valid,
  input wire logic i_hsync,
  input wire logic i_vsync,
  output logic o_pix_ready,
  // Core side: received words
  output logic o_word_valid,
  output disp_host_pkg::host_word_t o_word,
  input wire logic i_word_ready,
  output logic o_word_lost,
  // Core side: read data and serial read phase
  input wire logic [disp_host_pkg::BUS_W-1:0] i_rd_data,
  input wire logic i_ser_rd_en,
  output logic o_rd_done,
  // Core side: pixels
  output logic o_pix_valid,
  output disp_host_pkg::pixel_t o_pix,
  input wire logic i_pix_ready
);

  // Two-flop synchroniser for every pin sampled in the core domain
  logic [disp_host_pkg::PIN_W-1:0] pin_raw;
  logic [disp_host_pkg::PIN_W-1:0] pin_meta_ff;
  logic [disp_host_pkg::PIN_W-1:0] pin_ff;
  logic [disp_host_pkg::PIN_W-1:0] pin_prev_ff;
  assign pin_raw = {i_parallel_pixel_bus, i_sda, i_read_strobe_n, i_write_strobe_or_dc_select,
                    i_dc_select_or_serial_clock, i_interface_mode_select_bit, i_chip_select_n};

  always_ff @(posedge i_ref_clk) begin
    pin_meta_ff <= pin_raw;
    pin_ff <= pin_meta_ff;
    pin_prev_ff <= pin_ff;
  end

  // Decoded pin roles
  wire sel_w = ~pin_ff[disp_host_pkg::PIN_CS];
  wire mode_hi_w = pin_ff[disp_host_pkg::PIN_MODE];
  wire is_par_w = (i_host_mode == disp_host_pkg::MODE_PARALLEL);
  wire [disp_host_pkg::BUS_W-1:0] bus_w = pin_ff[disp_host_pkg::PIN_BUS +: disp_host_pkg::BUS_W];
  wire dcsck_rise_w = pin_ff[disp_host_pkg::PIN_DCSCK] & ~pin_prev_ff[disp_host_pkg::PIN_DCSCK];
  wire dcsck_fall_w = ~pin_ff[disp_host_pkg::PIN_DCSCK] & pin_prev_ff[disp_host_pkg::PIN_DCSCK];
  wire wr_rise_w = pin_ff[disp_host_pkg::PIN_WRDC] & ~pin_prev_ff[disp_host_pkg::PIN_WRDC];
  wire rd_rise_w = pin_ff[disp_host_pkg::PIN_RD] & ~pin_prev_ff[disp_host_pkg::PIN_RD];
  wire rd_low_w = ~pin_ff[disp_host_pkg::PIN_RD];
  wire sda_w = pin_ff[disp_host_pkg::PIN_SDA];
  wire lane2_w = pin_ff[disp_host_pkg::PIN_WRDC];
  wire two_lane_w = (i_host_mode == disp_host_pkg::MODE_SERIAL2LANE);
  wire three_wire_w = (i_host_mode == disp_host_pkg::MODE_SERIAL3);

  // Parallel path: write strobe edge takes a word, dc select from register select pin
  wire par_wr_w = sel_w & is_par_w & wr_rise_w;
  wire par_rd_w = sel_w & is_par_w & rd_rise_w;

  // Serial path: one bit per rising clock, two in the two-lane mode
  logic [3:0] ser_cnt_ff;
  logic [disp_host_pkg::BUS_W-1:0] ser_shift_ff;
  logic ser_dc_ff;
  logic ser_dc_seen_ff;
  logic [3:0] ser_out_idx_ff;
  wire ser_edge_w = sel_w & ~is_par_w & dcsck_rise_w;
  wire [3:0] ser_step_w = two_lane_w ? 4'h2 : 4'h1;
  wire ser_last_w = ser_edge_w & ((ser_cnt_ff + ser_step_w) > disp_host_pkg::SER_LAST);
  // Three-wire mode spends the first bit on data/command select
  wire ser_dc_bit_w = ser_edge_w & three_wire_w & ~ser_dc_seen_ff;
  wire ser_data_edge_w = ser_edge_w & ~ser_dc_bit_w;
  wire ser_done_w = ser_data_edge_w & ser_last_w;
  // Four-wire mode takes data/command select from the write strobe pin
  wire ser4_dc_w = lane2_w;
  wire [disp_host_pkg::BUS_W-1:0] nxt_ser_shift = two_lane_w ?
      {ser_shift_ff[disp_host_pkg::BUS_W-3:0], sda_w, lane2_w} :
      {ser_shift_ff[disp_host_pkg::BUS_W-2:0], sda_w};
  wire nxt_ser_dc = three_wire_w ? ser_dc_ff : ser4_dc_w;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !sel_w) begin
      ser_cnt_ff <= disp_host_pkg::SER_CNT_RST;
      ser_shift_ff <= '0;
      ser_dc_ff <= 1'b0;
      ser_dc_seen_ff <= 1'b0;
    end else if (ser_dc_bit_w) begin
      ser_dc_ff <= sda_w;
      ser_dc_seen_ff <= 1'b1;
    end else if (ser_data_edge_w) begin
      ser_shift_ff <= nxt_ser_shift;
      ser_cnt_ff <= ser_last_w ? disp_host_pkg::SER_CNT_RST : ser_cnt_ff + ser_step_w;
      ser_dc_ff <= nxt_ser_dc;
      ser_dc_seen_ff <= ser_last_w ? 1'b0 : ser_dc_seen_ff;
    end
  end

  // Serial read: the bit index steps on the falling clock so data is stable at the rise
  wire ser_drive_w = sel_w & ~is_par_w & ~mode_hi_w & i_ser_rd_en;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !sel_w) begin
      ser_out_idx_ff <= disp_host_pkg::SER_LAST;
    end else if (ser_drive_w && dcsck_fall_w && ser_out_idx_ff != 4'h0) begin
      ser_out_idx_ff <= ser_out_idx_ff - 4'h1;
    end
  end

  // Pin drivers; the bus is only driven during a selected parallel read
  logic sda_ff;
  logic sda_oe_ff;
  logic [disp_host_pkg::BUS_W-1:0] bus_out_ff;
  logic bus_oe_ff;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sda_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      bus_out_ff <= '0;
      bus_oe_ff <= 1'b0;
    end else begin
      sda_ff <= i_rd_data[ser_out_idx_ff];
      sda_oe_ff <= ser_drive_w;
      bus_out_ff <= i_rd_data;
      bus_oe_ff <= sel_w & is_par_w & rd_low_w;
    end
  end
  assign o_sda = sda_ff;
  assign o_sda_oe = sda_oe_ff;
  assign o_parallel_pixel_bus = bus_out_ff;
  assign o_parallel_pixel_bus_oe = bus_oe_ff;

  // Word holding register; a word that finds it still full is counted as lost
  wire take_w = par_wr_w | ser_done_w;
  wire host_word_t_dc_w = par_wr_w ? pin_ff[disp_host_pkg::PIN_DCSCK] : nxt_ser_dc;
  wire [disp_host_pkg::BUS_W-1:0] take_val_w = par_wr_w ? bus_w : nxt_ser_shift;
  logic word_valid_ff;
  disp_host_pkg::host_word_t word_ff;
  logic lost_ff;
  logic rd_done_ff;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      word_valid_ff <= 1'b0;
      word_ff <= disp_host_pkg::WORD_RST;
      lost_ff <= 1'b0;
      rd_done_ff <= 1'b0;
    end else begin
      word_valid_ff <= take_w | (word_valid_ff & ~i_word_ready);
      if (take_w && (!word_valid_ff || i_word_ready)) begin
        word_ff <= '{is_data: host_word_t_dc_w, value: take_val_w};
      end
      lost_ff <= take_w & word_valid_ff & ~i_word_ready;
      rd_done_ff <= par_rd_w;
    end
  end
  assign o_word_valid = word_valid_ff;
  assign o_word = word_ff;
  assign o_word_lost = lost_ff;
  assign o_rd_done = rd_done_ff;

  // RGB path: reset brought into the dot clock domain
  logic dot_rst_meta_ff;
  logic dot_rst_ff;
  always_ff @(posedge i_dot_clk) begin
    dot_rst_meta_ff <= i_rst;
    dot_rst_ff <= dot_rst_meta_ff;
  end

  // Two-entry buffer with gray pointers; a full buffer drops the pixel and shows not ready
  disp_host_pkg::pixel_t pix_mem [disp_host_pkg::PIX_DEPTH];
  logic [1:0] wbin_ff;
  logic [1:0] rbin_ff;
  logic [1:0] rgray_meta_ff;
  logic [1:0] rgray_dot_ff;
  logic [1:0] wgray_meta_ff;
  logic [1:0] wgray_ref_ff;
  wire [1:0] wgray_w = wbin_ff ^ (wbin_ff >> 1);
  wire [1:0] rgray_w = rbin_ff ^ (rbin_ff >> 1);
  wire full_w = (wgray_w == ~rgray_dot_ff);
  wire empty_w = (rgray_w == wgray_ref_ff);
  wire pix_push_w = i_pixel_data_valid & ~full_w;
  wire pix_pop_w = ~empty_w & i_pix_ready;
  assign o_pix_ready = ~full_w;

  always_ff @(posedge i_dot_clk) begin
    rgray_meta_ff <= rgray_w;
    rgray_dot_ff <= rgray_meta_ff;
    if (dot_rst_ff) begin
      wbin_ff <= disp_host_pkg::PTR_RST;
    end else if (pix_push_w) begin
      wbin_ff <= wbin_ff + disp_host_pkg::PTR_ONE;
      pix_mem[wbin_ff[0]] <= '{hsync: i_hsync, vsync: i_vsync, px: i_parallel_pixel_bus};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    wgray_meta_ff <= wgray_w;
    wgray_ref_ff <= wgray_meta_ff;
    if (i_rst) begin
      rbin_ff <= disp_host_pkg::PTR_RST;
    end else if (pix_pop_w) begin
      rbin_ff <= rbin_ff + disp_host_pkg::PTR_ONE;
    end
  end
  assign o_pix_valid = ~empty_w;
  assign o_pix = pix_mem[rbin_ff[0]];

  // Checks
  sequence s_rd_edge;
    ~i_rst & sel_w & is_par_w & rd_low_w ##1 ~rd_low_w & sel_w;
  endsequence

  a_sda_input_only: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $past(mode_hi_w) |-> !o_sda_oe) else $error("serial pin driven with mode select high");
  a_sda_read_drive: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ser_drive_w |=> o_sda_oe) else $error("serial read data not driven");
  a_read_done_edge: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_rd_edge |=> o_rd_done) else $error("read completion missed");
  a_bus_idle_release: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !sel_w |=> !o_parallel_pixel_bus_oe) else $error("bus driven while deselected");
  a_cs_gates_words: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !sel_w |-> !take_w) else $error("word taken while deselected");
  a_par_dc_kind: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    par_wr_w && !word_valid_ff |=> o_word.is_data == $past(pin_ff[disp_host_pkg::PIN_DCSCK]))
    else $error("data or command kind wrong");
  a_ser_bit_count: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ser_data_edge_w && !two_lane_w && !ser_last_w |=> ser_cnt_ff == $past(ser_cnt_ff) + 4'h1)
    else $error("serial bit not counted");
  a_ser_word_out: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ser_done_w |=> o_word_valid) else $error("serial word not delivered");
  a_pix_capture: assert property (@(posedge i_dot_clk) disable iff (dot_rst_ff)
    i_pixel_data_valid && !full_w |=> wbin_ff == $past(wbin_ff) + disp_host_pkg::PTR_ONE)
    else $error("pixel not captured");
  a_pix_ignore: assert property (@(posedge i_dot_clk) disable iff (dot_rst_ff)
    !i_pixel_data_valid |=> $stable(wbin_ff)) else $error("pixel taken without enable");
endmodule : disp_host_port

// >>> host_pins.sv
`timescale 1ns/1ps
// Host at the far side of the pins: strobes, serial frames, RGB bursts
module host_pins (
  // Pacing clock
  input wire logic i_ref_clk,
  // Pins toward the device
  output logic o_cs_n,
  output logic o_dc_sck,
  output logic o_wr_dc,
  output logic o_rd_n,
  output logic o_sda,
  output logic [17:0] o_bus,
  output logic o_dot,
  output logic o_de,
  output logic o_hs,
  output logic o_vs
);
  // Idle levels: deselected, read strobe high, write strobe low, dot clock still
  initial begin
    {o_cs_n, o_dc_sck, o_wr_dc, o_rd_n, o_sda} = 5'h1a;
    {o_bus, o_dot, o_de, o_hs, o_vs} = 22'h000000;
  end
  // Four core cycles a step, so every level outlives the synchroniser
  task automatic step();
    repeat (4) @(posedge i_ref_clk);
  endtask : step
  // Parallel write; the bus is inverted afterwards so a stale word is not seen
  task automatic par_write(input logic sel, input logic dc, input logic [17:0] v);
    o_cs_n <= ~sel;
    o_dc_sck <= dc;
    o_bus <= v;
    step();
    o_wr_dc <= 1'b0;
    step();
    o_wr_dc <= 1'b1;
    step();
    o_cs_n <= 1'b1;
    o_bus <= ~v;
    step();
  endtask : par_write
  // Serial word, data set a full step ahead of each rising clock
  task automatic ser_word(input int n, input logic dc, input logic [7:0] b);
    logic [8:0] w;
    w = {dc, b};
    o_cs_n <= 1'b0;
    o_dc_sck <= 1'b0;
    o_wr_dc <= dc;
    step();
    for (int i = n - 1; i >= 0; i--) begin
      o_sda <= (n == 4) ? b[2*i+1] : w[i];
      if (n == 4) o_wr_dc <= b[2*i];
      step();
      o_dc_sck <= 1'b1;
      step();
      o_dc_sck <= 1'b0;
    end
    step();
    o_cs_n <= 1'b1;
    o_sda <= ~o_sda;
    o_wr_dc <= 1'b1;
    step();
  endtask : ser_word
  // Dot clock only inside a burst; enable only while pixels are on the bus
  task automatic dot_run(input int n, input logic de, inout int seed);
    #7;
    for (int i = 0; i < n; i++) begin
      o_de <= de;
      o_hs <= (i == 0);
      o_vs <= (i == n - 1);
      o_bus <= 18'($random(seed));
      #15 o_dot = 1'b1;
      #15 o_dot = 1'b0;
    end
    o_de <= 1'b0;
  endtask : dot_run
endmodule : host_pins

// >>> display_host_interface_pins_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the host pin port
module display_host_interface_pins_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  disp_host_pkg::host_mode_t mode = disp_host_pkg::MODE_PARALLEL;
  logic mode_bit = 1'b1;
  logic word_ready = 1'b1;
  logic ser_rd_en = 1'b0;
  logic pix_ready = 1'b1;
  logic stall = 1'b0;
  logic rdy_q = 1'b0;
  logic [17:0] rd_data = 18'h00000;
  logic cs_n, dc_sck, wr_dc, rd_n, h_sda, dot, de, hs, vs, sda_o, sda_oe, sda_w;
  logic bus_oe, pix_rdy, w_valid, w_lost, rd_done, p_valid;
  logic [17:0] h_bus, bus_o, bus_w;
  disp_host_pkg::host_word_t w;
  disp_host_pkg::pixel_t p;
  logic [19:0] got_w[$], got_p[$], exp_p[$];
  int n_mismatch = 0;
  int tests_run = 0;
  int n_lost = 0;
  int seed = 25993;
  // Wire levels: whoever enables drives, otherwise the host's value
  assign sda_w = sda_oe ? sda_o : h_sda;
  assign bus_w = bus_oe ? bus_o : h_bus;
  always #2.5 clk = ~clk;
  host_pins host (.i_ref_clk(clk), .o_cs_n(cs_n), .o_dc_sck(dc_sck), .o_wr_dc(wr_dc),
    .o_rd_n(rd_n), .o_sda(h_sda), .o_bus(h_bus), .o_dot(dot), .o_de(de), .o_hs(hs), .o_vs(vs));
  disp_host_port DUT (.i_ref_clk(clk), .i_rst(rst), .i_host_mode(mode),
    .i_interface_mode_select_bit(mode_bit), .i_chip_select_n(cs_n),
    .i_dc_select_or_serial_clock(dc_sck), .i_write_strobe_or_dc_select(wr_dc),
    .i_read_strobe_n(rd_n), .i_sda(sda_w), .o_sda(sda_o), .o_sda_oe(sda_oe),
    .i_parallel_pixel_bus(bus_w), .o_parallel_pixel_bus(bus_o),
    .o_parallel_pixel_bus_oe(bus_oe), .i_dot_clk(dot), .i_pixel_data_valid(de),
    .i_hsync(hs), .i_vsync(vs), .o_pix_ready(pix_rdy), .o_word_valid(w_valid),
    .o_word(w), .i_word_ready(word_ready), .o_word_lost(w_lost), .i_rd_data(rd_data),
    .i_ser_rd_en(ser_rd_en), .o_rd_done(rd_done), .o_pix_valid(p_valid), .o_pix(p),
    .i_pix_ready(pix_ready));
  // Collect accepted words and pixels; random pixel stalls
  always @(posedge clk) begin
    if (!rst && w_valid === 1'b1 && word_ready) got_w.push_back({1'b0, w});
    if (!rst && p_valid === 1'b1 && pix_ready) got_p.push_back(p);
    if (w_lost === 1'b1) n_lost++;
    pix_ready <= stall ? 1'b0 : ($random(seed) % 4 != 0);
  end
  // Ready is taken at the fall, since the buffer's own flops move on the rise
  always @(negedge dot) rdy_q = pix_rdy;
  always @(posedge dot) if (!rst && de && rdy_q === 1'b1) exp_p.push_back({hs, vs, h_bus});
  function automatic logic [19:0] exp_word(input logic dc, input logic [17:0] v);
    return {1'b0, dc, v};
  endfunction : exp_word
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  // Bounded wait for the next accepted word
  task automatic next_word(output logic [19:0] v);
    for (int k = 0; k < 64 && got_w.size() == 0; k++) @(posedge clk);
    v = (got_w.size() != 0) ? got_w.pop_front() : 20'hfffff;
  endtask : next_word
  task automatic stop_test();
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  // Main sequence
  initial begin
    logic [19:0] v;
    logic [17:0] r;
    logic [7:0] b;
    logic dc;
    host.dot_run(6, 1'b0, seed);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // The dot domain leaves reset only on dot edges, so give it idle ones first
    host.dot_run(3, 1'b0, seed);
    repeat (6) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      r = (i == 3) ? 18'h3ffff : 18'($random(seed));
      host.par_write(1'b1, i[0], r);
      next_word(v);
      check("parallel word", v, exp_word(i[0], r));
    end
    host.par_write(1'b0, 1'b1, 18'h2aaaa);
    check("deselected write", 20'(got_w.size()), 20'h00000);
    word_ready <= 1'b0;
    host.par_write(1'b1, 1'b0, 18'h00001);
    host.par_write(1'b1, 1'b1, 18'h00002);
    word_ready <= 1'b1;
    next_word(v);
    check("held word", v, exp_word(1'b0, 18'h00001));
    check("lost pulses", 20'(n_lost), 20'h00001);
    for (int m = 1; m < 4; m++) begin
      mode <= disp_host_pkg::host_mode_t'(m);
      for (int i = 0; i < 3; i++) begin
        b = (i == 0) ? 8'h80 : 8'($random(seed));
        dc = 1'($random(seed));
        host.ser_word((m == 3) ? 4 : (m == 1) ? 9 : 8, dc, b);
        next_word(v);
        if (m == 3) v[18] = 1'b0;
        check("serial word", v, exp_word((m == 3) ? 1'b0 : dc, {10'h000, b}));
      end
    end
    rd_data <= 18'($random(seed));
    ser_rd_en <= 1'b1;
    mode_bit <= 1'b0;
    host.o_cs_n <= 1'b0;
    repeat (2) host.step();
    check("serial drive", 20'({sda_oe, sda_o}), 20'({1'b1, rd_data[7]}));
    // One serial clock pulse; the falling edge moves the read index to the next bit
    host.o_dc_sck <= 1'b1;
    host.step();
    host.o_dc_sck <= 1'b0;
    repeat (2) host.step();
    check("serial next bit", 20'(sda_o), 20'(rd_data[6]));
    mode_bit <= 1'b1;
    repeat (2) host.step();
    check("input only pin", 20'(sda_oe), 20'h00000);
    ser_rd_en <= 1'b0;
    mode <= disp_host_pkg::MODE_PARALLEL;
    host.o_rd_n <= 1'b0;
    repeat (2) host.step();
    check("read bus", {1'b0, bus_oe, bus_o}, {2'b01, rd_data});
    host.o_rd_n <= 1'b1;
    for (int k = 0; k < 8 && rd_done !== 1'b1; k++) @(posedge clk);
    check("read done", 20'(rd_done), 20'h00001);
    host.o_cs_n <= 1'b1;
    stall <= 1'b1;
    host.dot_run(4, 1'b1, seed);
    check("buffer full", 20'(pix_rdy), 20'h00000);
    stall <= 1'b0;
    host.dot_run(3, 1'b0, seed);
    host.dot_run(12, 1'b1, seed);
    repeat (30) @(posedge clk);
    check("pixel count", 20'(got_p.size()), 20'(exp_p.size()));
    while (got_p.size() != 0 && exp_p.size() != 0)
      check("pixel", got_p.pop_front(), exp_p.pop_front());
    stop_test();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #300000;
    n_mismatch++;
    stop_test();
  end
endmodule : display_host_interface_pins_tb
